// ===== hw/tst_trip_regs.sv
// Temperature reading and alarm-window limit registers with trip-status bits
module tst_trip_regs
  import tst_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [TST_PTR_W-1:0] i_reg_ptr,
  input wire logic [TST_REG_W-1:0] i_wr_data,
  input wire logic i_window_lock,
  input wire logic i_conv_done,
  input wire logic [TST_CONV_W-1:0] i_conv_temp,
  input wire logic [TST_REG_W-1:0] i_crit_limit,
  input wire logic [1:0] i_hyst_sel,
  output logic [TST_REG_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic [TST_REG_W-1:0] o_temp_reading,
  output logic [TST_REG_W-1:0] o_upper_limit,
  output logic [TST_REG_W-1:0] o_lower_limit
);

  logic [TST_REG_W-1:0] upper_limit_value_ff;
  logic [TST_REG_W-1:0] lower_limit_value_ff;
  logic [TST_CONV_W-1:0] conv_temp_ff;
  logic [TST_REG_W-1:0] temp_word_ff;
  logic [TST_REG_W-1:0] rd_data_ff;
  logic rd_valid_ff;
  logic [TST_REG_W-1:0] conv_word;
  logic [TST_REG_W-1:0] nxt_temp_word;
  logic [TST_REG_W-1:0] nxt_rd_data;
  logic signed [13:0] temp_cmp;
  logic [13:0] hyst_cnt;
  logic over_critical_flag;
  logic over_window_flag;
  logic under_window_flag;
  logic wr_upper;
  logic wr_lower;

  // Writes land only when the window is unlocked
  assign wr_upper = i_wr_en && (i_reg_ptr == TST_PTR_UPPER) && !i_window_lock;
  assign wr_lower = i_wr_en && (i_reg_ptr == TST_PTR_LOWER) && !i_window_lock;

  // Upper limit; reserved bits are masked so they never hold a one
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      upper_limit_value_ff <= TST_LIMIT_RESET;
    end else if (wr_upper) begin
      upper_limit_value_ff <= i_wr_data & TST_LIMIT_MASK;
    end
  end

  // Lower limit, same layout as the upper one
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lower_limit_value_ff <= TST_LIMIT_RESET;
    end else if (wr_lower) begin
      lower_limit_value_ff <= i_wr_data & TST_LIMIT_MASK;
    end
  end

  // Converter result is taken only on a completed conversion
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_temp_ff <= TST_CONV_RESET;
    end else if (i_conv_done) begin
      conv_temp_ff <= i_conv_temp;
    end
  end

  // Sign at 12, 0.125 degC value at 11:1, bit 0 tied low
  assign conv_word = {3'h0, conv_temp_ff, 1'b0};
  assign temp_cmp = tst_to_cmp(conv_word);
  assign hyst_cnt = tst_hyst_counts(i_hyst_sel);

  // Flags compare against the live limit registers, so a write acts at once
  tst_trip_flag #(.KIND(TST_TRIP_ABOVE_INCL)) u_crit (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_temp(temp_cmp),
    .i_thr(tst_to_cmp(i_crit_limit)),
    .i_hyst(hyst_cnt),
    .o_flag(over_critical_flag)
  );

  tst_trip_flag #(.KIND(TST_TRIP_ABOVE)) u_over (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_temp(temp_cmp),
    .i_thr(tst_to_cmp(upper_limit_value_ff)),
    .i_hyst(hyst_cnt),
    .o_flag(over_window_flag)
  );

  tst_trip_flag #(.KIND(TST_TRIP_BELOW)) u_under (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_temp(temp_cmp),
    .i_thr(tst_to_cmp(lower_limit_value_ff)),
    .i_hyst(hyst_cnt),
    .o_flag(under_window_flag)
  );

  // Status bits above sign; no event pin state feeds them
  always_comb begin
    nxt_temp_word = conv_word;
    nxt_temp_word[TST_CRIT_BIT] = over_critical_flag;
    nxt_temp_word[TST_OVER_BIT] = over_window_flag;
    nxt_temp_word[TST_UNDER_BIT] = under_window_flag;
  end

  // Whole reading word in one flop; status bits trail the value bits by one cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      temp_word_ff <= TST_TEMP_RESET;
    end else begin
      temp_word_ff <= nxt_temp_word;
    end
  end

  // Read decode; unknown pointers return zero
  always_comb begin
    unique case (i_reg_ptr)
      TST_PTR_UPPER: nxt_rd_data = upper_limit_value_ff;
      TST_PTR_LOWER: nxt_rd_data = lower_limit_value_ff;
      TST_PTR_TEMP: nxt_rd_data = temp_word_ff;
      default: nxt_rd_data = 16'h0000;
    endcase
  end

  // Read data is a one-cycle snapshot of the full 16-bit word
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= i_rd_en;
      if (i_rd_en) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_temp_reading = temp_word_ff;
  assign o_upper_limit = upper_limit_value_ff;
  assign o_lower_limit = lower_limit_value_ff;

  property p_upper_rsvd;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_wr_en |=> ((o_upper_limit & ~TST_LIMIT_MASK) == 16'h0000);
  endproperty
  a_upper_rsvd: assert property (p_upper_rsvd) else $error("Upper reserved bit set");

  property p_lower_rsvd;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_wr_en |=> ((o_lower_limit & ~TST_LIMIT_MASK) == 16'h0000);
  endproperty
  a_lower_rsvd: assert property (p_lower_rsvd) else $error("Lower reserved bit set");

  property p_upper_write;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_wr_en && i_reg_ptr == TST_PTR_UPPER && !i_window_lock)
      |=> (o_upper_limit == ($past(i_wr_data) & TST_LIMIT_MASK));
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("Upper write lost");

  property p_lower_write;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_wr_en && i_reg_ptr == TST_PTR_LOWER && !i_window_lock)
      |=> (o_lower_limit == ($past(i_wr_data) & TST_LIMIT_MASK));
  endproperty
  a_lower_write: assert property (p_lower_write) else $error("Lower write lost");

  property p_lock;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_window_lock |=> ($stable(o_upper_limit) && $stable(o_lower_limit));
  endproperty
  a_lock: assert property (p_lock) else $error("Limit changed while locked");

  property p_lsb_zero;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_conv_done |-> ##2 (o_temp_reading[0] == 1'b0);
  endproperty
  a_lsb_zero: assert property (p_lsb_zero) else $error("Reading bit 0 not zero");

  property p_conv_refresh;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_conv_done ##1 !i_conv_done) |=> (o_temp_reading[12:1] == $past(i_conv_temp, 2));
  endproperty
  a_conv_refresh: assert property (p_conv_refresh) else $error("Reading not refreshed");

  property p_over_status;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (temp_cmp > tst_to_cmp(upper_limit_value_ff))[*2] |=> o_temp_reading[TST_OVER_BIT];
  endproperty
  a_over_status: assert property (p_over_status) else $error("Over-window bit missing");

  property p_crit_status;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (temp_cmp >= tst_to_cmp(i_crit_limit))[*2] |=> o_temp_reading[TST_CRIT_BIT];
  endproperty
  a_crit_status: assert property (p_crit_status) else $error("Critical bit missing");

  property p_under_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (temp_cmp >= tst_to_cmp(lower_limit_value_ff))[*2] |=> !o_temp_reading[TST_UNDER_BIT];
  endproperty
  a_under_clear: assert property (p_under_clear) else $error("Under-window bit stuck");

  property p_read_temp;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_rd_en && i_reg_ptr == TST_PTR_TEMP) |=> (o_rd_valid && o_rd_data == $past(temp_word_ff));
  endproperty
  a_read_temp: assert property (p_read_temp) else $error("Temperature read torn");

  // Set side of the under-window flag, below the lower limit less hysteresis
  property p_under_status;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (temp_cmp < (tst_to_cmp(lower_limit_value_ff) - $signed(hyst_cnt)))[*2]
      |=> o_temp_reading[TST_UNDER_BIT];
  endproperty
  a_under_status: assert property (p_under_status) else $error("Under bit missing");

  // Valid follows each read strobe by exactly one cycle and never stands alone
  property p_rd_valid;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_rd_valid == $past(i_rd_en);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("Read valid misplaced");

endmodule : tst_trip_regs

// ===== hw/tst_pkg.sv
// Package: register pointers, field layout, reset values and hysteresis steps of the trip bank
//
// Overview of operation
// - Temperatures and limits are 13-bit two's complement, sign at bit 12, 0.0625 degC per count.
// - Reading resolution is 0.125 degC; bit 0 always reads zero.
// - Bit 11 of the temperature value weighs 128 degC, below the sign.
// - Top three reading bits report trip status from present temperature and limits.
// - Trip status is independent of event pin enable, mask or clear.
// - Status bits sit above sign and value, e.g. 1FFEh versus FFFEh.
// - Upper limit holds sign at bit 12, value bits 11:2, 0.25 degC steps.
// - Upper limit bits 15:13 and 1:0 ignore writes and read zero.
// - Lower limit holds sign at bit 12, value bits 11:2, 0.25 degC steps.
// - Lower limit bits 15:13 and 1:0 ignore writes and read zero.
// - Comparisons always use the limits currently held, effective right after writes.
// - Under-window bit 13 sets below lower minus hysteresis, clears at lower.
// - Over-window bit 14 sets above upper, clears below upper minus hysteresis.
// - Critical bit 15 sets at critical limit, clears below critical minus hysteresis.
// - While the window lock is set, writes to both limits are rejected.
package tst_pkg;

  localparam int TST_REG_W = 16;
  localparam int TST_PTR_W = 4;

  // Register pointers as seen by the serial protocol engine
  localparam logic [3:0] TST_PTR_UPPER = 4'h2;
  localparam logic [3:0] TST_PTR_LOWER = 4'h3;
  localparam logic [3:0] TST_PTR_TEMP = 4'h5;

  // Field positions of the temperature reading
  localparam int TST_CRIT_BIT = 15;
  localparam int TST_OVER_BIT = 14;
  localparam int TST_UNDER_BIT = 13;
  localparam int TST_SIGN_BIT = 12;
  localparam int TST_CONV_W = 12;

  // Writable bits of a limit register: sign at 12, value at 11:2
  localparam logic [15:0] TST_LIMIT_MASK = 16'h1ffc;
  localparam logic [15:0] TST_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] TST_TEMP_RESET = 16'h0000;
  localparam logic [11:0] TST_CONV_RESET = 12'h000;

  // Hysteresis in 0.0625 degC counts: 0, 1.5, 3 and 6 degC
  localparam logic [13:0] TST_HYST_0 = 14'h0000;
  localparam logic [13:0] TST_HYST_1 = 14'h0018;
  localparam logic [13:0] TST_HYST_2 = 14'h0030;
  localparam logic [13:0] TST_HYST_3 = 14'h0060;

  typedef enum logic [1:0] {
    TST_TRIP_ABOVE_INCL,
    TST_TRIP_ABOVE,
    TST_TRIP_BELOW
  } tst_trip_kind_type;

  // Sign-extends a 13-bit two's complement field to the 14-bit compare width
  function automatic logic signed [13:0] tst_to_cmp(input logic [15:0] word);
    tst_to_cmp = $signed({word[TST_SIGN_BIT], word[12:0]});
  endfunction : tst_to_cmp

  // Maps the hysteresis selector to a count
  function automatic logic [13:0] tst_hyst_counts(input logic [1:0] sel);
    unique case (sel)
      2'h0: tst_hyst_counts = TST_HYST_0;
      2'h1: tst_hyst_counts = TST_HYST_1;
      2'h2: tst_hyst_counts = TST_HYST_2;
      2'h3: tst_hyst_counts = TST_HYST_3;
    endcase
  endfunction : tst_hyst_counts

endpackage : tst_pkg

// ===== hw/tst_trip_flag.sv
// One trip-status flag with hysteresis against a single threshold
module tst_trip_flag
  import tst_pkg::*;
#(
  parameter tst_trip_kind_type KIND = TST_TRIP_ABOVE
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic signed [13:0] i_temp,
  input wire logic signed [13:0] i_thr,
  input wire logic [13:0] i_hyst,
  output logic o_flag
);

  logic signed [13:0] thr_low;
  logic set_cond;
  logic clr_cond;
  logic flag_ff;
  logic nxt_flag;

  // Lower edge of the hysteresis band; limits span 13 bits so 14 bits never wrap
  assign thr_low = i_thr - $signed(i_hyst);

  // Set and clear points per flag kind
  always_comb begin
    unique case (KIND)
      TST_TRIP_ABOVE_INCL: begin
        set_cond = (i_temp >= i_thr);
        clr_cond = (i_temp < thr_low);
      end
      TST_TRIP_ABOVE: begin
        set_cond = (i_temp > i_thr);
        clr_cond = (i_temp < thr_low);
      end
      default: begin
        set_cond = (i_temp < thr_low);
        clr_cond = (i_temp >= i_thr);
      end
    endcase
  end

  // Inside the band the flag keeps its previous state
  assign nxt_flag = flag_ff ? ~clr_cond : set_cond;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;

  property p_flag_set;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    set_cond |=> flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Trip flag failed to set");

  property p_flag_hold;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!set_cond && !clr_cond) |=> (flag_ff == $past(flag_ff));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Trip flag moved inside band");

endmodule : tst_trip_flag

// ===== test/tst_host_model.sv
// Host-side model: issues register writes and reads and notes the expected read words
module tst_host_model
  import tst_pkg::*;
(
  input wire logic i_ref_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [TST_PTR_W-1:0] o_reg_ptr,
  output logic [TST_REG_W-1:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [TST_REG_W-1:0] exp_q[$];

  // Idle bus at time zero
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_reg_ptr = 4'h0;
    o_wr_data = 16'h0000;
  end

  // No event output listens here, so limits may change without gating interrupts
  task automatic wr(input logic [3:0] ptr, input logic [15:0] data);
    @(negedge i_ref_clk);
    o_wr_en = 1'b1;
    o_reg_ptr = ptr;
    o_wr_data = data;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_wr_data = ~data; // Released data must not keep its last value
  endtask : wr

  // One-cycle read strobe; expected word queued at the request
  task automatic rd(input logic [3:0] ptr, input logic [15:0] exp);
    @(negedge i_ref_clk);
    o_rd_en = 1'b1;
    o_reg_ptr = ptr;
    exp_q.push_back(exp);
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_reg_ptr = ~ptr;
  endtask : rd
endmodule : tst_host_model

// ===== test/tb_temp_trip_point_registers.sv
// Self-checking bench for the trip-point register bank
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_temp_trip_point_registers
  import tst_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic wr_en, rd_en, window_lock, conv_done, rd_valid, fc, fo, fu;
  logic [3:0] reg_ptr;
  logic [15:0] wr_data, crit_limit, rd_data, temp_reading, upper_limit, lower_limit;
  logic [15:0] up_w, lo_w, rd_exp;
  logic [11:0] conv_temp;
  logic [1:0] hyst_sel;
  logic [11:0] dirs [6] = '{12'h0c8, 12'h3e8, 12'hfff, 12'h800, 12'h400, 12'he48};
  int hy [4] = '{int'(TST_HYST_0), int'(TST_HYST_1), int'(TST_HYST_2), int'(TST_HYST_3)};
  int n_errors = 0;
  int n_tests = 0;
  int seed = 74849;

  tst_trip_regs DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_reg_ptr(reg_ptr), .i_wr_data(wr_data), .i_window_lock(window_lock),
    .i_conv_done(conv_done), .i_conv_temp(conv_temp), .i_crit_limit(crit_limit),
    .i_hyst_sel(hyst_sel), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_temp_reading(temp_reading), .o_upper_limit(upper_limit), .o_lower_limit(lower_limit));

  tst_host_model host (.i_ref_clk(i_ref_clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_reg_ptr(reg_ptr), .o_wr_data(wr_data));

  // 20 MHz reference clock
  always #25 i_ref_clk = ~i_ref_clk;

  // Sign-extends a 13-bit field
  function automatic int sx(input logic [12:0] v);
    return $signed(v);
  endfunction : sx

  // Flag model with hysteresis; hold band keeps the previous state
  task automatic step();
    int t, u, l, c, h;
    t = sx({conv_temp, 1'b0});
    u = sx(up_w[12:0]);
    l = sx(lo_w[12:0]);
    c = sx(crit_limit[12:0]);
    h = hy[hyst_sel];
    if (t >= c) fc = 1'b1; else if (t < c - h) fc = 1'b0;
    if (t > u) fo = 1'b1; else if (t < u - h) fo = 1'b0;
    if (t < l - h) fu = 1'b1; else if (t >= l) fu = 1'b0;
  endtask : step

  // Reading checked at the port and through a register read
  task automatic chk_read();
    logic [15:0] e;
    e = {fc, fo, fu, conv_temp, 1'b0};
    `CHK("temp_reading", e, temp_reading)
    host.rd(TST_PTR_TEMP, e);
  endtask : chk_read

  // Write with expected effect; a locked bank keeps its limits
  task automatic wl(input logic [3:0] ptr, input logic [15:0] d);
    if (window_lock !== 1'b1 && ptr == TST_PTR_UPPER) up_w = d & TST_LIMIT_MASK;
    if (window_lock !== 1'b1 && ptr == TST_PTR_LOWER) lo_w = d & TST_LIMIT_MASK;
    host.wr(ptr, d);
    @(negedge i_ref_clk);
    `CHK("upper_limit", up_w, upper_limit)
    `CHK("lower_limit", lo_w, lower_limit)
    host.rd(TST_PTR_UPPER, up_w);
    host.rd(TST_PTR_LOWER, lo_w);
  endtask : wl

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Read-data watcher: oldest note against each valid pulse
  always @(negedge i_ref_clk) begin
    if (rd_valid === 1'b1) begin
      rd_exp = host.exp_q.pop_front();
      `CHK("rd_data", rd_exp, rd_data)
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {window_lock, conv_done, fc, fo, fu} = 5'h00;
    conv_temp = 12'h000;
    crit_limit = 16'h07d0;
    hyst_sel = 2'h0;
    up_w = 16'h0000;
    lo_w = 16'h0000;
    repeat (5) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    `CHK("upper_rst", 16'h0000, upper_limit)
    `CHK("lower_rst", 16'h0000, lower_limit)
    host.rd(4'h0, 16'h0000); // Unmapped pointer reads zero
    wl(TST_PTR_UPPER, 16'hffff);
    wl(TST_PTR_TEMP, 16'hffff); // Read-only reading ignores writes
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        // Mid-run power-on reset: the only way the window lock may fall again
        i_reset_n = 1'b0;
        {window_lock, fc, fo, fu} = 4'h0;
        conv_temp = 12'h000;
        up_w = 16'h0000;
        lo_w = 16'h0000;
        repeat (2) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        // Flags restart from the inputs that stand at the first edge after release
        step();
        `CHK("upper_rst", 16'h0000, upper_limit)
        `CHK("lower_rst", 16'h0000, lower_limit)
        `CHK("temp_rst", 16'h0000, temp_reading)
      end
      @(negedge i_ref_clk);
      hyst_sel = 2'($random(seed));
      crit_limit = 16'($random(seed)) & TST_LIMIT_MASK;
      repeat (4) @(negedge i_ref_clk);
      step();
      conv_temp = (i < 6) ? dirs[i] : 12'($random(seed));
      conv_done = 1'b1;
      @(negedge i_ref_clk);
      conv_done = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      step();
      chk_read();
      // Lock only ever rises; late in each half it may set and then sticks until reset
      if ((i % 20) >= 12) window_lock = window_lock | 1'($random(seed));
      wl(($random(seed) & 1) ? TST_PTR_UPPER : TST_PTR_LOWER, 16'($random(seed)));
      repeat (3) @(negedge i_ref_clk);
      step();
      chk_read();
    end
    repeat (4) @(negedge i_ref_clk);
    `CHK("rd_queue", 0, host.exp_q.size())
    end_of_test();
  end
endmodule : tb_temp_trip_point_registers
